// ==== core/smpd_consts.vh ====
`ifndef SMPD_CONSTS_VH
`define SMPD_CONSTS_VH
// Lane-width field codes
`define SMPD_MODE_4X2 2'h0
`define SMPD_MODE_8 2'h1
`define SMPD_MODE_16 2'h2
`define SMPD_MODE_WIDE 2'h3
// Descriptor field positions
`define SMPD_D_HDR 19
`define SMPD_D_MODE_HI 18
`define SMPD_D_MODE_LO 17
`define SMPD_D_TYPE_HI 16
`define SMPD_D_TYPE_LO 12
// Header write-mask and force-level-zero positions
`define SMPD_H_FLZ 16
`define SMPD_H_MASK_HI 15
`define SMPD_H_MASK_LO 12
// Narrow-mode message types
`define SMPD_T_SAMPLE 5'h00
`define SMPD_T_BIAS 5'h01
`define SMPD_T_LEVEL 5'h02
`define SMPD_T_CMP 5'h03
`define SMPD_T_GRAD 5'h04
`define SMPD_T_LOAD 5'h07
`define SMPD_T_DIMQ 5'h0A
`define SMPD_T_KILL 5'h0C
`define SMPD_T_GRADC 5'h14
// Wide-mode message types
`define SMPD_W_UNORM 5'h00
`define SMPD_W_UNORMK 5'h02
`define SMPD_W_VBF 5'h03
`define SMPD_W_DEINT 5'h08
`define SMPD_W_UNORM_M 5'h0C
`define SMPD_W_UNORMK_M 5'h0A
`define SMPD_W_VBF_M 5'h0B
`define SMPD_W_FLUSH 5'h1F
// Length limits and response counts
`define SMPD_MAX_LEN 5'h0B
`define SMPD_MAX_P16 4'h5
`define SMPD_RSP_4X2 5'h01
`define SMPD_RSP_8 5'h04
`define SMPD_RSP_8K 5'h05
`define SMPD_RSP_16 5'h08
`define SMPD_RSP_UN 5'h08
`define SMPD_RSP_UNK 5'h09
`define SMPD_RSP_VBF 5'h10
`define SMPD_RSP_FLUSH 5'h01
// Level-selection modes
`define SMPD_LOD_GRAD 2'h0
`define SMPD_LOD_GRADB 2'h1
`define SMPD_LOD_EXPL 2'h2
`define SMPD_LOD_ZERO 2'h3
`endif

// ==== core/smpd_decoder.v ====
// What this block does
// - Expected length is header plus parameter phases scaled by lane mode.
// - Response is 1, 4 or 5, or 8 phases by lane mode.
// - Sixteen-lane response shrinks two phases per masked channel.
// - Omitted higher parameters default to zero.
// - Header flag selects first phase as header, else dispatch default.
// - Parameters are float except integer load and dimension query.
// - Five-bit type code selects operation; layout follows lane mode.
// - Video block filter returns sixteen, minus four per masked channel.
// - Wide pixel lookup returns eight or nine, with no reduction for header masks.
// - Field-interleave removal length comes from filter state fields.
// - Plain lookup uses gradient level; extra coords ignored, missing zero.
// - Kill-mask lookup returns an extra register holding the kill mask.
// - Biased lookup adds bias to gradient level before selection.
// - Explicit-level lookup uses the supplied level, no computation.
// - Compare lookup compares reference to red, returns white or black.
// - Lane field: 0 pair, 1 eight, 2 sixteen, 3 wide.
// - No header means all header fields zero.
`timescale 1ns/1ps
`include "smpd_consts.vh"
module smpd_decoder (
  input wire ref_clk,
  input wire rstn,
  input wire clkEn,
  input wire reqValid,
  input wire [31:0] reqDescriptor,
  input wire [4:0] reqLength,
  input wire [3:0] paramCount,
  input wire [31:0] headerPhase,
  input wire [31:0] dispatchHeader,
  input wire [4:0] deintRespLength,
  output reg decValid,
  output reg [1:0] laneMode,
  output reg [4:0] opType,
  output reg [4:0] expectLength,
  output reg [4:0] respLength,
  output reg [31:0] activeHeader,
  output reg [10:0] paramPresent,
  output reg paramInteger,
  output reg [1:0] lodMode,
  output reg addBias,
  output reg compareRed,
  output reg killMaskPhase,
  output reg protoError
);
  // ----------------------------------------
  // Descriptor decode
  // ----------------------------------------
  wire hdrFlag = reqDescriptor[`SMPD_D_HDR];
  wire [1:0] mode = reqDescriptor[`SMPD_D_MODE_HI:`SMPD_D_MODE_LO];
  wire [4:0] typ = reqDescriptor[`SMPD_D_TYPE_HI:`SMPD_D_TYPE_LO];
  // Without a header every field reads as zero, so all channels unmasked
  wire [31:0] hdr = hdrFlag ? headerPhase : 32'h00000000;
  wire [3:0] chMask = hdr[`SMPD_H_MASK_HI:`SMPD_H_MASK_LO];
  wire flz = hdr[`SMPD_H_FLZ];
  wire [2:0] nMasked = {2'h0, chMask[0]} + {2'h0, chMask[1]} + {2'h0, chMask[2]}
    + {2'h0, chMask[3]};
  wire isWide = (mode == `SMPD_MODE_WIDE);

  // ----------------------------------------
  // Expected request length
  // ----------------------------------------
  reg [4:0] next_expect;
  reg [4:0] paramPhases;
  always @* begin
    case (mode)
      `SMPD_MODE_4X2: paramPhases = {3'h0, paramCount[3:2]} + {4'h0, |paramCount[1:0]};
      `SMPD_MODE_8: paramPhases = {1'h0, paramCount};
      `SMPD_MODE_16: paramPhases = {paramCount, 1'h0};
      default: paramPhases = 5'h01;
    endcase
    if (isWide && typ == `SMPD_W_FLUSH)
      next_expect = 5'h01;
    else
      next_expect = paramPhases + {4'h0, hdrFlag};
  end

  // ----------------------------------------
  // Response length
  // ----------------------------------------
  reg [4:0] next_resp;
  always @* begin
    case (mode)
      `SMPD_MODE_4X2: next_resp = `SMPD_RSP_4X2;
      `SMPD_MODE_8: next_resp = (typ == `SMPD_T_KILL) ? `SMPD_RSP_8K : `SMPD_RSP_8;
      `SMPD_MODE_16: next_resp = `SMPD_RSP_16 - {1'h0, nMasked, 1'h0};
      default: begin
        case (typ)
          `SMPD_W_VBF, `SMPD_W_VBF_M: next_resp = `SMPD_RSP_VBF - {nMasked, 2'h0};
          // Pixel lookup masks come from the type itself, not the header
          `SMPD_W_UNORM, `SMPD_W_UNORM_M: next_resp = `SMPD_RSP_UN;
          `SMPD_W_UNORMK, `SMPD_W_UNORMK_M: next_resp = `SMPD_RSP_UNK;
          `SMPD_W_DEINT: next_resp = deintRespLength;
          `SMPD_W_FLUSH: next_resp = `SMPD_RSP_FLUSH;
          default: next_resp = 5'h00;
        endcase
      end
    endcase
  end

  // ----------------------------------------
  // Operation semantics
  // ----------------------------------------
  reg [1:0] next_lod;
  reg next_bias;
  reg next_cmp;
  always @* begin
    next_lod = `SMPD_LOD_GRAD;
    next_bias = 1'b0;
    next_cmp = 1'b0;
    if (!isWide) begin
      case (typ)
        `SMPD_T_BIAS: begin
          next_lod = `SMPD_LOD_GRADB;
          next_bias = 1'b1;
        end
        `SMPD_T_LEVEL: next_lod = `SMPD_LOD_EXPL;
        `SMPD_T_CMP: next_cmp = 1'b1;
        default: next_lod = `SMPD_LOD_GRAD;
      endcase
    end
    // Forced zero still passes through bias and explicit-level override
    if (flz && next_lod == `SMPD_LOD_GRAD)
      next_lod = `SMPD_LOD_ZERO;
  end

  // ----------------------------------------
  // Protocol checks
  // ----------------------------------------
  reg next_err;
  always @* begin
    next_err = 1'b0;
    if (reqLength > `SMPD_MAX_LEN) next_err = 1'b1;
    if (reqLength != next_expect) next_err = 1'b1;
    if (mode == `SMPD_MODE_16 && paramCount > `SMPD_MAX_P16) next_err = 1'b1;
    if (mode == `SMPD_MODE_16 && (typ == `SMPD_T_GRAD || typ == `SMPD_T_GRADC))
      next_err = 1'b1;
    if (mode == `SMPD_MODE_4X2 && (typ == `SMPD_T_SAMPLE || typ == `SMPD_T_BIAS))
      next_err = 1'b1;
    if (!isWide && mode != `SMPD_MODE_8 && typ == `SMPD_T_KILL) next_err = 1'b1;
    if (mode == `SMPD_MODE_4X2 && typ == `SMPD_T_CMP && !flz) next_err = 1'b1;
    // All four channels masked would return nothing useful
    if (!isWide && chMask == 4'hF) next_err = 1'b1;
  end

  // Parameters past the sent count are flagged absent and read as zero
  wire [10:0] next_present = (11'h001 << paramCount) - 11'h001;

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      decValid <= 1'b0;
      laneMode <= 2'h0;
      opType <= 5'h00;
      expectLength <= 5'h00;
      respLength <= 5'h00;
      activeHeader <= 32'h00000000;
      paramPresent <= 11'h000;
      paramInteger <= 1'b0;
      lodMode <= 2'h0;
      addBias <= 1'b0;
      compareRed <= 1'b0;
      killMaskPhase <= 1'b0;
      protoError <= 1'b0;
    end else if (clkEn) begin
      decValid <= reqValid;
      if (reqValid) begin
        laneMode <= mode;
        opType <= typ;
        expectLength <= next_expect;
        respLength <= next_err ? 5'h00 : next_resp;
        activeHeader <= hdrFlag ? headerPhase : dispatchHeader;
        paramPresent <= (paramCount > 4'hB) ? 11'h7FF : next_present;
        paramInteger <= !isWide && (typ == `SMPD_T_LOAD || typ == `SMPD_T_DIMQ);
        lodMode <= next_lod;
        addBias <= next_bias;
        compareRed <= next_cmp;
        killMaskPhase <= (mode == `SMPD_MODE_8 && typ == `SMPD_T_KILL)
          || (isWide && (typ == `SMPD_W_UNORMK || typ == `SMPD_W_UNORMK_M));
        protoError <= next_err;
      end
    end
  end
endmodule // smpd_decoder

// ==== bench/smpd_decoder_checker.sv ====
`timescale 1ns/1ps
module smpd_decoder_checker (
  input wire ref_clk,
  input wire rstn,
  input wire clkEn,
  input wire reqValid,
  input wire [31:0] reqDescriptor,
  input wire [4:0] reqLength,
  input wire [31:0] headerPhase,
  input wire decValid,
  input wire [1:0] laneMode,
  input wire [4:0] opType,
  input wire [4:0] respLength,
  input wire [31:0] activeHeader,
  input wire killMaskPhase,
  input wire protoError
);
  // ----
  // Properties
  // ----
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_take;
    clkEn && reqValid;
  endsequence
  sequence s_good;
    decValid && !protoError;
  endsequence
  a_take_answer: assert property (s_take |=> decValid)
    else $error("no decode after request");
  a_idle_quiet: assert property (clkEn && !reqValid |=> !decValid)
    else $error("decode without request");
  a_long_error: assert property (s_take ##0 reqLength > 5'h0B |=> protoError)
    else $error("long message not flagged");
  a_grad_sixteen: assert property (s_take ##0 reqDescriptor[18:12] == 7'h44 |=> protoError)
    else $error("sixteen-lane gradient not flagged");
  a_pair_forced: assert property (s_take ##0 reqDescriptor[18:12] == 7'h03
    && !headerPhase[16] |=> protoError)
    else $error("pair compare without forced level");
  a_error_empty: assert property (decValid && protoError |-> respLength == 5'h00)
    else $error("error with nonzero response");
  a_pair_one: assert property (s_good ##0 laneMode == 2'h0 |-> respLength == 5'h01)
    else $error("pair response not one");
  a_eight_kill: assert property (s_good ##0 laneMode == 2'h1 |->
    respLength == (opType == 5'h0C ? 5'h05 : 5'h04) && killMaskPhase == (opType == 5'h0C))
    else $error("eight-lane response wrong");
  a_header_pick: assert property (s_take ##0 reqDescriptor[19] |=>
    activeHeader == $past(headerPhase))
    else $error("header phase not used");
endmodule // smpd_decoder_checker
bind smpd_decoder smpd_decoder_checker i_chk (.*);

// ==== bench/smpd_thread.sv ====
`timescale 1ns/1ps
// Thread side: sizes its messages; pad breaks the size on purpose
module smpd_thread (
  input wire [31:0] reqDescriptor,
  input wire [3:0] paramCount,
  input wire [4:0] pad,
  output wire [4:0] reqLength
);
  wire [1:0] m = reqDescriptor[18:17];
  wire [4:0] n = {1'b0, paramCount};
  // Pair mode packs four parameters a phase, so round up
  assign reqLength = pad + {4'h0, reqDescriptor[19]} + (m == 2'h0 ? (n + 5'h03) >> 2 :
    m == 2'h1 ? n : m == 2'h2 ? {n[3:0], 1'b0} : 5'h01);
  // No bias values travel here, so the bias range is never left
endmodule // smpd_thread

// ==== bench/smpd_decoder_bench.sv ====
`timescale 1ns/1ps
module smpd_decoder_bench;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg clkEn = 1'b1;
  reg reqValid = 1'b0;
  reg hf = 1'b1;
  reg [31:0] reqDescriptor = 32'h0;
  reg [3:0] paramCount = 4'h0;
  reg [4:0] pad = 5'h00;
  reg [31:0] headerPhase = 32'h0;
  reg [31:0] dispatchHeader = 32'h00A40300;
  reg [4:0] deintRespLength = 5'h06;
  wire [4:0] reqLength, opType, expectLength, respLength;
  wire decValid, paramInteger, addBias, compareRed, killMaskPhase, protoError;
  wire [1:0] laneMode, lodMode;
  wire [31:0] activeHeader;
  wire [10:0] paramPresent;
  integer n_fail = 0;
  integer check_count = 0;
  smpd_decoder i_smpd_decoder (.*);
  smpd_thread i_smpd_thread (.*);
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Header mk is {force level zero, channel masks}
  task go(input [1:0] m, input [4:0] t, input [3:0] k, input [4:0] p, input [4:0] mk);
    begin
      reqDescriptor = {12'h000, hf, m, t, 12'h000};
      headerPhase = {15'h0000, mk, 12'h000};
      paramCount = k;
      pad = p;
      reqValid = 1'b1;
      @(negedge ref_clk);
      reqValid = 1'b0;
      @(negedge ref_clk);
    end
  endtask
  task bad(input e);
    begin
      chk(protoError, e);
      if (e)
        chk(respLength, 0);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_size;
    begin
      go(1, 5'h0C, 3, 0, 0);
      chk(opType, 5'h0C);
      chk(expectLength, 4);
      chk(killMaskPhase, 1);
      go(0, 5'h07, 5, 0, 0);
      chk(expectLength, 3);
      chk(paramInteger, 1);
      go(2, 5'h00, 3, 0, 0);
      chk(expectLength, 7);
      chk(laneMode, 2);
      chk(respLength, 8);
    end
  endtask
  task t_mask;
    begin
      go(2, 5'h00, 3, 0, 5'h03);
      chk(respLength, 4);
      go(3, 5'h03, 0, 0, 5'h01);
      chk(respLength, 12);
      go(3, 5'h00, 0, 0, 5'h0F);
      chk(respLength, 8);
      go(3, 5'h02, 0, 0, 0);
      chk(respLength, 9);
      go(3, 5'h08, 0, 0, 0);
      chk(respLength, deintRespLength);
    end
  endtask
  task t_err;
    begin
      go(1, 5'h00, 3, 1, 0);
      bad(1);
      go(2, 5'h00, 6, 0, 0);
      bad(1);
      go(2, 5'h04, 2, 0, 0);
      bad(1);
      go(0, 5'h01, 4, 0, 0);
      bad(1);
      go(2, 5'h0C, 3, 0, 0);
      bad(1);
      go(0, 5'h03, 4, 0, 0);
      bad(1);
      go(0, 5'h03, 4, 0, 5'h10);
      bad(0);
      chk(lodMode, 3);
    end
  endtask
  task t_lod;
    begin
      go(1, 5'h01, 4, 0, 0);
      chk(addBias, 1);
      go(1, 5'h02, 4, 0, 0);
      chk(lodMode, 2);
      go(1, 5'h03, 4, 0, 0);
      chk(compareRed, 1);
      go(1, 5'h00, 3, 0, 0);
      chk(lodMode, 0);
      chk(paramPresent, 11'h007);
      hf = 1'b0;
      go(2, 5'h00, 2, 0, 5'h0F);
      chk(activeHeader, dispatchHeader);
      chk(respLength, 8);
      hf = 1'b1;
    end
  endtask
  // Enable low must freeze every result, then decoding resumes
  task t_hold;
    begin
      go(1, 5'h0C, 3, 0, 0);
      clkEn = 1'b0;
      go(2, 5'h00, 3, 0, 0);
      chk(respLength, 5);
      chk(killMaskPhase, 1);
      chk(laneMode, 1);
      clkEn = 1'b1;
      go(2, 5'h00, 3, 0, 0);
      chk(respLength, 8);
    end
  endtask
  task results;
    begin
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Run is about seventy cycles; allow several times that
  initial begin
    #40000;
    n_fail = n_fail + 1;
    results;
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    t_size;
    t_mask;
    t_err;
    t_lod;
    t_hold;
    results;
  end
endmodule // smpd_decoder_bench
